//--- rtl/rac_top.sv
// region attribute configuration bank for regions 44 to 63
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - word 12 sits at 0x7EC and is 64 bits in the 64-bit format, 32 bits in the 32-bit one.
// - word 13 at 0x7ED exists only in the 32-bit format.
// - word 14 sits at 0x7EE with width following the active format.
// - word 15 at 0x7EF exists only in the 32-bit format.
// - in the 64-bit format word 12 holds regions 55 to 52 in bits 63:32.
// - word 12 bits 31:0 hold regions 51 to 48 in both formats.
// - the 32-bit word 11 holds regions 47 to 44, region 44 lowest.
// - the 32-bit word 13 holds regions 55 to 52, region 52 lowest.
// - in the 64-bit format word 14 holds regions 63 to 56, region 56 lowest.
// - the 32-bit word 15 holds regions 63 to 60, region 60 lowest.
// - every region byte uses one shared encoding of speculation and cacheability.
// - bit 3 enables speculation, bits 7:4 are reserved yet writable.
// - code 000 means cacheable, and coherent on coherent cores.
// - code 010 means uncacheable.
// - code 011 means uncached accelerated.
module rac_top (
    input wire logic mclk, // clock, 200 MHz
    input wire logic rst, // sync reset, active high
    input wire logic fmt64, // 1: 64-bit format, 0: 32-bit format
    input wire logic coherent_core, // core has cache coherency
    input wire logic csr_wr, // register write strobe
    input wire logic csr_rd, // register read strobe
    input wire logic [11:0] csr_addr, // register address
    input wire logic [63:0] csr_wdata, // write data
    input wire logic [5:0] lookup_region, // region to decode
    output logic [63:0] csr_rdata, // read data, registered
    output logic csr_hit, // address implemented, registered
    output rac_pkg::rac_attr_s lookup_attr // decoded attributes, registered
);
    rac_pkg::rac_csr_req_s req;
    logic [19:0] byte_we;
    logic [159:0] byte_wdata;
    logic [159:0] byte_q;
    logic [63:0] rdata_next;
    logic hit_next;
    logic [7:0] sel_byte;
    rac_pkg::rac_attr_s attr_dec;
    logic [4:0] lidx;
    logic lin_range;

    assign req = '{wr: csr_wr, rd: csr_rd, addr: csr_addr, wdata: csr_wdata};

    // write steering: each word maps onto a run of region bytes set by its address and the active format
    always_comb begin
        byte_we = '0;
        byte_wdata = '0;
        if (req.wr) begin
            unique case (req.addr)
                rac_pkg::ADDR_WORD_11: begin
                    if (!fmt64) begin
                        byte_we[3:0] = 4'hF;
                        byte_wdata[31:0] = req.wdata[31:0];
                    end
                end
                rac_pkg::ADDR_WORD_12: begin
                    byte_we[7:4] = 4'hF;
                    byte_wdata[63:32] = req.wdata[31:0];
                    if (fmt64) begin
                        byte_we[11:8] = 4'hF;
                        byte_wdata[95:64] = req.wdata[63:32];
                    end
                end
                rac_pkg::ADDR_WORD_13: begin
                    if (!fmt64) begin
                        byte_we[11:8] = 4'hF;
                        byte_wdata[95:64] = req.wdata[31:0];
                    end
                end
                rac_pkg::ADDR_WORD_14: begin
                    byte_we[15:12] = 4'hF;
                    byte_wdata[127:96] = req.wdata[31:0];
                    if (fmt64) begin
                        byte_we[19:16] = 4'hF;
                        byte_wdata[159:128] = req.wdata[63:32];
                    end
                end
                rac_pkg::ADDR_WORD_15: begin
                    if (!fmt64) begin
                        byte_we[19:16] = 4'hF;
                        byte_wdata[159:128] = req.wdata[31:0];
                    end
                end
                default: byte_we = '0;
            endcase
        end
    end

    rac_store u_store (
        .mclk(mclk),
        .rst(rst),
        .byte_we(byte_we),
        .byte_wdata(byte_wdata),
        .byte_q(byte_q)
    );

    // read mux; words absent in the current format read zero with no hit
    always_comb begin
        rdata_next = '0;
        hit_next = 1'b0;
        unique case (req.addr)
            rac_pkg::ADDR_WORD_11: begin
                hit_next = !fmt64;
                if (!fmt64) rdata_next[31:0] = byte_q[31:0];
            end
            rac_pkg::ADDR_WORD_12: begin
                hit_next = 1'b1;
                rdata_next[31:0] = byte_q[63:32];
                if (fmt64) rdata_next[63:32] = byte_q[95:64];
            end
            rac_pkg::ADDR_WORD_13: begin
                hit_next = !fmt64;
                if (!fmt64) rdata_next[31:0] = byte_q[95:64];
            end
            rac_pkg::ADDR_WORD_14: begin
                hit_next = 1'b1;
                rdata_next[31:0] = byte_q[127:96];
                if (fmt64) rdata_next[63:32] = byte_q[159:128];
            end
            rac_pkg::ADDR_WORD_15: begin
                hit_next = !fmt64;
                if (!fmt64) rdata_next[31:0] = byte_q[159:128];
            end
            default: hit_next = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            csr_rdata <= rac_pkg::WORD_RESET;
            csr_hit <= 1'b0;
        end else begin
            csr_rdata <= req.rd ? rdata_next : rac_pkg::WORD_RESET;
            csr_hit <= (req.rd | req.wr) & hit_next;
        end
    end

    // lookup: regions outside 44..63 belong to other banks and decode as zero
    assign lin_range = (lookup_region >= 6'(rac_pkg::FIRST_REGION));
    assign lidx = 5'(lookup_region - 6'(rac_pkg::FIRST_REGION));
    assign sel_byte = lin_range ? byte_q[lidx*8 +: 8] : 8'h00;

    rac_decode u_decode (
        .attr_byte(sel_byte),
        .coherent_core(coherent_core),
        .attr(attr_dec)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            lookup_attr <= '0;
        end else begin
            lookup_attr <= lin_range ? attr_dec : '0;
        end
    end
endmodule // rac_top
`default_nettype wire

//--- rtl/rac_pkg.sv
// package for the region attribute configuration bank
package rac_pkg;
    localparam logic [11:0] ADDR_WORD_11 = 12'h7EB;
    localparam logic [11:0] ADDR_WORD_12 = 12'h7EC;
    localparam logic [11:0] ADDR_WORD_13 = 12'h7ED;
    localparam logic [11:0] ADDR_WORD_14 = 12'h7EE;
    localparam logic [11:0] ADDR_WORD_15 = 12'h7EF;
    localparam int FIRST_REGION = 44;
    localparam int NUM_REGIONS = 20;
    localparam int SPEC_BIT = 3;
    localparam logic [2:0] CODE_CACHEABLE = 3'h0;
    localparam logic [2:0] CODE_UNCACHEABLE = 3'h2;
    localparam logic [2:0] CODE_UNCACHED_ACCEL = 3'h3;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [63:0] WORD_RESET = 64'h0000000000000000;

    typedef struct packed {
        logic [3:0] reserved;
        logic spec_en;
        logic [2:0] cacheability_code;
    } rac_byte_s;

    typedef struct packed {
        logic cacheable;
        logic coherent;
        logic uncacheable;
        logic accelerated;
        logic spec_en;
        logic illegal;
    } rac_attr_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [63:0] wdata;
    } rac_csr_req_s;
endpackage : rac_pkg

//--- rtl/rac_decode.sv
// decodes one region attribute byte into access attributes
`timescale 1ns/1ps
`default_nettype none
module rac_decode (
    input wire logic [7:0] attr_byte, // raw region attribute byte
    input wire logic coherent_core, // core supports coherency
    output rac_pkg::rac_attr_s attr // decoded attributes
);
    rac_pkg::rac_byte_s b;
    assign b = rac_pkg::rac_byte_s'(attr_byte);
    always_comb begin
        attr = '0;
        attr.spec_en = b.spec_en;
        unique case (b.cacheability_code)
            rac_pkg::CODE_CACHEABLE: begin
                attr.cacheable = 1'b1;
                attr.coherent = coherent_core;
            end
            rac_pkg::CODE_UNCACHEABLE: attr.uncacheable = 1'b1;
            rac_pkg::CODE_UNCACHED_ACCEL: begin
                attr.uncacheable = 1'b1;
                attr.accelerated = 1'b1;
            end
            // reserved codes: software must not use them, treated as uncached
            default: begin
                attr.uncacheable = 1'b1;
                attr.illegal = 1'b1;
            end
        endcase
    end
endmodule // rac_decode
`default_nettype wire

//--- rtl/rac_store.sv
// storage of the twenty region attribute bytes, one byte lane each
`timescale 1ns/1ps
`default_nettype none
module rac_store (
    input wire logic mclk, // clock
    input wire logic rst, // sync reset, active high
    input wire logic [19:0] byte_we, // per-region write strobes
    input wire logic [159:0] byte_wdata, // write data, region 44 lowest
    output logic [159:0] byte_q // stored bytes, region 44 lowest
);
    genvar i;
    generate
        for (i = 0; i < rac_pkg::NUM_REGIONS; i++) begin : g_byte
            // one private register per lane keeps a single writer per variable
            logic [7:0] lane_reg;
            always_ff @(posedge mclk) begin
                if (rst) begin
                    lane_reg <= rac_pkg::BYTE_RESET;
                end else if (byte_we[i]) begin
                    lane_reg <= byte_wdata[i*8 +: 8];
                end
            end
            assign byte_q[i*8 +: 8] = lane_reg;
        end
    endgenerate
endmodule // rac_store
`default_nettype wire

//--- verif/rac_monitor.sv
// port assertions for the region attribute bank
`timescale 1ns/1ps
`default_nettype none
module rac_monitor (
    input wire logic mclk, // clock
    input wire logic rst, // sync reset
    input wire logic fmt64, // format
    input wire logic coherent_core, // coherency
    input wire logic csr_wr, // write strobe
    input wire logic csr_rd, // read strobe
    input wire logic [11:0] csr_addr, // address
    input wire logic [63:0] csr_wdata, // write data
    input wire logic [5:0] lookup_region, // region
    input wire logic [63:0] csr_rdata, // read data
    input wire logic csr_hit, // hit
    input wire rac_pkg::rac_attr_s lookup_attr // decode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_odd64; (csr_wr || csr_rd) && fmt64 && csr_addr[0] |=> !csr_hit; endproperty
    a_odd64: assert property (p_odd64) else $error("odd word hit in 64-bit format");
    property p_hit12; (csr_wr || csr_rd) && csr_addr == rac_pkg::ADDR_WORD_12 |=> csr_hit; endproperty
    a_hit12: assert property (p_hit12) else $error("word 12 missed");
    property p_hit14; (csr_wr || csr_rd) && csr_addr == rac_pkg::ADDR_WORD_14 |=> csr_hit; endproperty
    a_hit14: assert property (p_hit14) else $error("word 14 missed");
    property p_upper32; csr_rd && !fmt64 |=> csr_rdata[63:32] == 32'h0; endproperty
    a_upper32: assert property (p_upper32) else $error("upper half set in 32-bit format");
    property p_wr_rd12;
        csr_wr && fmt64 && csr_addr == rac_pkg::ADDR_WORD_12 ##1 !csr_wr ##1
        csr_rd && !csr_wr && fmt64 && csr_addr == rac_pkg::ADDR_WORD_12
        |=> csr_rdata == $past(csr_wdata, 3);
    endproperty
    a_wr_rd12: assert property (p_wr_rd12) else $error("word 12 readback wrong");
    property p_coh; lookup_attr.coherent |-> lookup_attr.cacheable && $past(coherent_core); endproperty
    a_coh: assert property (p_coh) else $error("coherent without cause");
    property p_accel; lookup_attr.accelerated |-> lookup_attr.uncacheable && !lookup_attr.cacheable; endproperty
    a_accel: assert property (p_accel) else $error("accelerated not uncached");
    property p_unc; lookup_attr.uncacheable |-> !lookup_attr.cacheable && !lookup_attr.coherent; endproperty
    a_unc: assert property (p_unc) else $error("uncacheable also cacheable");
endmodule // rac_monitor
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the region attribute bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 0, rst = 1, fmt64 = 0, coherent_core = 0, csr_wr = 0, csr_rd = 0;
    logic [11:0] csr_addr = 12'h7EB;
    logic [11:0] addr_pick;
    logic [63:0] csr_wdata = 64'h0;
    logic [5:0] lookup_region = 6'h00;
    logic [63:0] csr_rdata;
    logic csr_hit;
    rac_pkg::rac_attr_s lookup_attr;
    logic [7:0] mem [20];
    int failures = 0, checks = 0, cyc = 0;
    rac_top rac_top_i (.mclk(mclk), .rst(rst), .fmt64(fmt64), .coherent_core(coherent_core),
        .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
        .lookup_region(lookup_region), .csr_rdata(csr_rdata), .csr_hit(csr_hit),
        .lookup_attr(lookup_attr));
    always #2.5 mclk = ~mclk;
    function automatic logic hit_of(input logic [11:0] a, input logic f);
        return a >= 12'h7EB && a <= 12'h7EF && !(f && a[0]);
    endfunction
    function automatic logic [63:0] exp_word(input logic [11:0] a, input logic f);
        logic [63:0] w;
        w = 64'h0;
        if (hit_of(a, f))
            for (int k = 0; k < (f ? 8 : 4); k++) w[8*k +: 8] = mem[(a - 12'h7EB) * 4 + k];
        return w;
    endfunction
    function automatic rac_pkg::rac_attr_s exp_attr(input logic [5:0] r, input logic cc);
        logic [7:0] b;
        logic bad;
        if (r < 6'h2C) return '0;
        b = mem[r - 6'h2C];
        bad = b[2:0] == 3'h1 || b[2];
        return '{cacheable: b[2:0] == 3'h0, coherent: b[2:0] == 3'h0 && cc,
            uncacheable: b[1] || bad, accelerated: b[2:0] == 3'h3, spec_en: b[3], illegal: bad};
    endfunction
    // software never programs reserved codes: map them onto uncacheable
    function automatic logic [63:0] legal(input logic [63:0] d);
        logic [63:0] w;
        w = d;
        for (int k = 0; k < 8; k++)
            if (w[8*k +: 3] == 3'h1 || w[8*k + 2]) w[8*k +: 3] = 3'h2;
        return w;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one idle cycle between tasks; the readback assertion counts on it
    task automatic wr(input logic [11:0] a, input logic [63:0] d);
        @(posedge mclk);
        csr_wr <= 1'b1;
        csr_addr <= a;
        csr_wdata <= d;
        @(posedge mclk);
        csr_wr <= 1'b0;
        if (hit_of(a, fmt64))
            for (int k = 0; k < (fmt64 ? 8 : 4); k++) mem[(a - 12'h7EB) * 4 + k] = d[8*k +: 8];
        #1 chk(64'(csr_hit), 64'(hit_of(a, fmt64)));
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge mclk);
        csr_rd <= 1'b1;
        csr_addr <= a;
        @(posedge mclk);
        csr_rd <= 1'b0;
        #1 chk(csr_rdata, exp_word(a, fmt64));
        chk(64'(csr_hit), 64'(hit_of(a, fmt64)));
    endtask
    task automatic print_verdict;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(49));
        // bytes come up zero, the value the design picks for undefined
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 'h7EA; a <= 'h7F0; a++) rd(12'(a));
        $display("test reset done");
        wr(12'h7EB, 64'hFAFAFAFAFAFAFAFA);
        rd(12'h7EB);
        repeat (300) begin
            @(posedge mclk);
            fmt64 <= 1'($urandom);
            coherent_core <= 1'($urandom);
            lookup_region <= 6'h28 + 6'($urandom % 24);
            addr_pick = 12'h7EA + 12'($urandom % 7);
            wr(addr_pick, legal({$urandom, $urandom}));
            rd(addr_pick);
            chk(64'(lookup_attr), 64'(exp_attr(lookup_region, coherent_core)));
        end
        $display("test random done");
        print_verdict();
    end
endmodule // testbench
bind rac_top rac_monitor rac_monitor_i (.mclk(mclk), .rst(rst), .fmt64(fmt64),
    .coherent_core(coherent_core), .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .lookup_region(lookup_region), .csr_rdata(csr_rdata),
    .csr_hit(csr_hit), .lookup_attr(lookup_attr));
`default_nettype wire
